// ---- gptmc_defs.svh ----
// Constants for the timer mode and control block.
`ifndef GPTMC_DEFS_SVH
`define GPTMC_DEFS_SVH
// Overview of operation
// - Half B mode field: 1 one-shot, 2 periodic, 3 capture, 0 reserved.
// - In 16-bit configuration half B mode field governs half B alone.
// - In 32-bit configuration half B mode register ignored; half A mode used.
// - Half B debug freeze set stops half B only while debugger halts CPU.
// - Half B enable starts counting or arms capture; clearing disables half B.
// - Half A output invert set inverts the half A PWM output.
// - RTC counting allowed only while rtc count enable is set.
// - Half A edge select: 0 rising, 1 falling, 3 both, 2 reserved.
// - Half A debug freeze set stops half A only while debugger halts CPU.
// - Half A enable starts counting or arms capture; clearing disables half A.
// - Global config: 0 32-bit timer, 1 32-bit RTC, 4 to 7 two 16-bit halves.
`define GPTMC_OFS_CFG 12'h000
`define GPTMC_OFS_AMR 12'h004
`define GPTMC_OFS_BMR 12'h008
`define GPTMC_OFS_CTL 12'h00C
`define GPTMC_OFS_STAT 12'h050
`define GPTMC_CTL_WMASK 32'h0000035F
`define GPTMC_MR_WMASK 32'h0000000F
`define GPTMC_CFG_WMASK 32'h00000007
`define GPTMC_CTL_A_EN 0
`define GPTMC_CTL_A_FRZ 1
`define GPTMC_CTL_EDGE_LO 2
`define GPTMC_CTL_RTC_EN 4
`define GPTMC_CTL_A_INV 6
`define GPTMC_CTL_B_EN 8
`define GPTMC_CTL_B_FRZ 9
`define GPTMC_MR_ALT 3
`define GPTMC_MR_CAPK 2
`define GPTMC_CFG_SPLIT 2
`define GPTMC_CFG_RTC 3'h1
`define GPTMC_RESET_VAL 32'h00000000
`define GPTMC_RESP_OKAY 2'h0
`define GPTMC_RESP_SLVERR 2'h2
`endif

// ---- gptmc_pkg.sv ----
// Types shared by the timer mode and control block.
package gptmc_pkg;
   typedef enum logic [1:0] {
      GPTMC_MODE_RSVD = 2'h0,
      GPTMC_MODE_ONESHOT = 2'h1,
      GPTMC_MODE_PERIODIC = 2'h2,
      GPTMC_MODE_CAPTURE = 2'h3
   } gptmc_mode_type;
   typedef enum logic [1:0] {
      GPTMC_EDGE_POS = 2'h0,
      GPTMC_EDGE_NEG = 2'h1,
      GPTMC_EDGE_RSVD = 2'h2,
      GPTMC_EDGE_BOTH = 2'h3
   } gptmc_edge_type;
   // Decoded per-half control handed to the counters.
   typedef struct packed {
      logic run;
      logic count_en;
      logic capture;
      logic oneshot;
      logic periodic;
      logic pwm;
   } gptmc_half_type;
endpackage : gptmc_pkg

// ---- gptmc_half_dec.sv ----
// Mode decoder for one timer half.
`timescale 1ns/1ps
`default_nettype none
`include "gptmc_defs.svh"
module gptmc_half_dec (
   // Settings.
   input wire logic [3:0] mode_reg_i,
   input wire logic enable_i,
   input wire logic freeze_i,
   input wire logic dbg_halt_i,
   input wire logic active_i,
   // Decoded controls.
   output gptmc_pkg::gptmc_half_type ctl_o
);
   import gptmc_pkg::*;
   gptmc_mode_type mode;
   logic go;
   // Decodes mode, enable and debug freeze into the half's controls.
   always_comb begin
      mode = gptmc_mode_type'(mode_reg_i[1:0]);
      go = active_i & enable_i;
      ctl_o.run = go;
      ctl_o.count_en = go & ~(freeze_i & dbg_halt_i);
      ctl_o.capture = go & (mode == GPTMC_MODE_CAPTURE);
      ctl_o.oneshot = go & (mode == GPTMC_MODE_ONESHOT);
      ctl_o.periodic = go & (mode == GPTMC_MODE_PERIODIC);
      ctl_o.pwm = go & mode_reg_i[`GPTMC_MR_ALT] & ~mode_reg_i[`GPTMC_MR_CAPK]
         & (mode == GPTMC_MODE_PERIODIC);
   end
endmodule : gptmc_half_dec
`default_nettype wire

// ---- gptmc_top.sv ----
// Mode and control registers of the general-purpose timer, AXI4-Lite slave.
`timescale 1ns/1ps
`default_nettype none
`include "gptmc_defs.svh"
// Register front end and mode decode for a two-half timer; the counters
// themselves sit outside and only read the decoded controls.
// Registers update only through the bus, except the debug halt synchroniser, which follows its pin; nothing here counts time.
module gptmc_top #(
   // Flip-flops in the debug halt synchroniser.
   parameter int SYNC_STAGES = 3
) (
   // Clock and reset.
   input wire logic core_clk_i,
   input wire logic rst_i,
   // AXI4-Lite write channels.
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read channels.
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Debug halt from the processor, asynchronous.
   input wire logic dbg_halt_i,
   // Raw PWM level from the half A counter.
   input wire logic half_a_pwm_raw_i,
   // Decoded controls for the counters.
   output gptmc_pkg::gptmc_half_type half_a_ctl_o,
   output gptmc_pkg::gptmc_half_type half_b_ctl_o,
   output gptmc_pkg::gptmc_edge_type half_a_edge_select_o,
   output logic split_16_o,
   output logic rtc_count_o,
   output logic half_a_pwm_o
);
   import gptmc_pkg::*;

   // Refuses a synchroniser too short to let a metastable first stage settle.
   // Two stages of agreement are needed after the first one.
   if (SYNC_STAGES < 3) begin : g_sync_check
      $error("gptmc_top needs at least three synchroniser stages");
   end

   // ****************************************
   // Registers
   // ****************************************
   // Software-visible storage and the synchronised debug halt.
   logic [2:0] global_config_field_r;
   logic [3:0] half_a_mode_register_r;
   logic [3:0] half_b_mode_register_r;
   logic [9:0] timer_control_register_r;
   logic [SYNC_STAGES-1:0] halt_sync_r;
   logic dbg_halt_r;

   // ****************************************
   // AXI4-Lite slave
   // ****************************************
   // Holding flops for the write items and the combinational decode results.
   logic [11:0] aw_addr_r;
   logic aw_have_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic w_have_r;
   logic do_write;
   logic [31:0] wmask;
   logic [31:0] merged;
   logic [31:0] rd_val;
   logic rd_hit;
   logic wr_hit;

   // Each write item is refused while its holding flop is full or a response
   // is still unanswered, so at most one write is under way. The read address
   // is refused while read data waits. The write itself lands one edge after
   // both items are held, and the response is raised at that same edge, so
   // bvalid is first seen two edges after the later item is taken.
   assign s_axi_awready = ~aw_have_r & ~s_axi_bvalid;
   assign s_axi_wready = ~w_have_r & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign do_write = aw_have_r & w_have_r & ~s_axi_bvalid;

   // Captures address and data, in either order. Each item waits in its own
   // holding flop, so a master that offers data first is served as well as one
   // that offers the address first.
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= 12'h000;
         w_data_r <= `GPTMC_RESET_VAL;
         w_strb_r <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end else if (do_write) begin
            aw_have_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end else if (do_write) begin
            w_have_r <= 1'b0;
         end
      end
   end

   // Expands byte strobes into a bit mask and merges the new bytes into the
   // current word, so a partial write keeps the bytes it does not touch.
   always_comb begin
      wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
      merged = (w_data_r & wmask) | (rd_word(aw_addr_r) & ~wmask);
      wr_hit = (aw_addr_r == `GPTMC_OFS_CFG) || (aw_addr_r == `GPTMC_OFS_AMR) ||
         (aw_addr_r == `GPTMC_OFS_BMR) || (aw_addr_r == `GPTMC_OFS_CTL);
   end

   // Write response, SLVERR for unmapped or read-only addresses. The
   // response stands until the master shows bready, and no new write is
   // taken before then.
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `GPTMC_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? `GPTMC_RESP_OKAY : `GPTMC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Register word at an address; reserved bits read zero. The status word
   // gathers the decoded controls so software can see what the counters see.
   // The bit order of the status word is fixed here and nowhere else.
   function automatic logic [31:0] rd_word(input logic [11:0] a);
      logic [31:0] v;
      v = 32'h00000000;
      case (a)
         `GPTMC_OFS_CFG: v = {29'h0, global_config_field_r};
         `GPTMC_OFS_AMR: v = {28'h0, half_a_mode_register_r};
         `GPTMC_OFS_BMR: v = {28'h0, half_b_mode_register_r};
         `GPTMC_OFS_CTL: v = {22'h0, timer_control_register_r};
         `GPTMC_OFS_STAT: v = {24'h0, dbg_halt_r, rtc_count_o, split_16_o,
            half_b_ctl_o.count_en, half_b_ctl_o.run,
            half_a_ctl_o.count_en, half_a_ctl_o.run, half_a_pwm_o};
         default: v = 32'h00000000;
      endcase
      return v;
   endfunction : rd_word

   // Read decode straight from the address bus; the result is only stored at
   // the edge that takes the address, so later address changes do no harm.
   // Unmapped addresses read zero with an error response.
   always_comb begin
      rd_val = rd_word(s_axi_araddr);
      rd_hit = (s_axi_araddr == `GPTMC_OFS_CFG) || (s_axi_araddr == `GPTMC_OFS_AMR) ||
         (s_axi_araddr == `GPTMC_OFS_BMR) || (s_axi_araddr == `GPTMC_OFS_CTL) ||
         (s_axi_araddr == `GPTMC_OFS_STAT);
   end

   // Read data channel, one cycle after the address is taken. Data and
   // response stand unchanged until the master shows rready.
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= `GPTMC_RESET_VAL;
         s_axi_rresp <= `GPTMC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_val;
         s_axi_rresp <= rd_hit ? `GPTMC_RESP_OKAY : `GPTMC_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****************************************
   // Configuration storage
   // ****************************************

   // Global configuration field. Software is expected to set it while both
   // halves are disabled; a change on the fly takes effect at once and the
   // counters see the new decode in the next cycle.
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         global_config_field_r <= 3'h0;
      end else if (do_write && aw_addr_r == `GPTMC_OFS_CFG) begin
         global_config_field_r <= merged[2:0];
      end
   end

   // Mode registers; bits above 3 are reserved.
   // Half B mode is stored even in a 32-bit setup, where the decode ignores it.
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         half_a_mode_register_r <= 4'h0;
         half_b_mode_register_r <= 4'h0;
      end else if (do_write) begin
         if (aw_addr_r == `GPTMC_OFS_AMR) begin
            half_a_mode_register_r <= merged[3:0];
         end
         if (aw_addr_r == `GPTMC_OFS_BMR) begin
            half_b_mode_register_r <= merged[3:0];
         end
      end
   end

   // Control register; reserved bits 5 and 7 never store, so they read
   // back as zero whatever software writes there.
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         timer_control_register_r <= 10'h000;
      end else if (do_write && aw_addr_r == `GPTMC_OFS_CTL) begin
         timer_control_register_r <= 10'(merged & `GPTMC_CTL_WMASK);
      end
   end

   // ****************************************
   // Debug halt synchroniser
   // ****************************************

   // Shift chain; the level changes once the last two stages agree. Only the
   // second stage reads the first, so a metastable first stage never reaches
   // the decode. A halt shorter than two clock cycles may be missed, which is
   // harmless because a debugger halt lasts far longer. The synchronised
   // level lags the pin by three to four cycles.
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         halt_sync_r <= {SYNC_STAGES{1'b0}};
         dbg_halt_r <= 1'b0;
      end else begin
         halt_sync_r <= {halt_sync_r[SYNC_STAGES-2:0], dbg_halt_i};
         if (halt_sync_r[SYNC_STAGES-2] == halt_sync_r[SYNC_STAGES-1]) begin
            dbg_halt_r <= halt_sync_r[SYNC_STAGES-1];
         end
      end
   end

   // ****************************************
   // Mode decode
   // ****************************************
   // Configuration decode shared by both halves.
   logic split;
   logic rtc_cfg;
   logic [3:0] b_mode_eff;
   logic b_active;

   // Selects 16-bit split, RTC or 32-bit operation. Values 4 to 7 split the
   // module; 1 is the RTC setup; 0 and the reserved 2 and 3 give one 32-bit
   // timer, which half A decodes while half B stays idle. In a 32-bit setup
   // half B is fed the half A mode, yet with b_active low its decode stays all zero.
   // A reserved mode value of 0 decodes to no mode at all.
   always_comb begin
      split = global_config_field_r[`GPTMC_CFG_SPLIT];
      rtc_cfg = (global_config_field_r == `GPTMC_CFG_RTC);
      b_active = split;
      b_mode_eff = split ? half_b_mode_register_r : half_a_mode_register_r;
   end

   // Half A decode; it is idle in the RTC setup, where the wide counter
   // runs from the RTC enable instead.
   gptmc_half_dec u_half_a (
      .mode_reg_i(half_a_mode_register_r),
      .enable_i(timer_control_register_r[`GPTMC_CTL_A_EN]),
      .freeze_i(timer_control_register_r[`GPTMC_CTL_A_FRZ]),
      .dbg_halt_i(dbg_halt_r),
      .active_i(~rtc_cfg),
      .ctl_o(half_a_ctl_o)
   );

   // Half B decode; it only runs when the module is split.
   gptmc_half_dec u_half_b (
      .mode_reg_i(b_mode_eff),
      .enable_i(timer_control_register_r[`GPTMC_CTL_B_EN]),
      .freeze_i(timer_control_register_r[`GPTMC_CTL_B_FRZ]),
      .dbg_halt_i(dbg_halt_r),
      .active_i(b_active),
      .ctl_o(half_b_ctl_o)
   );

   // Edge select, RTC enable and output polarity. The inversion is a plain
   // gate, so the output follows its source in the same cycle. The RTC gate
   // also needs half A enabled, which starts the wide counter.
   always_comb begin
      half_a_edge_select_o = gptmc_edge_type'(
         timer_control_register_r[`GPTMC_CTL_EDGE_LO +: 2]);
      split_16_o = split;
      rtc_count_o = rtc_cfg & timer_control_register_r[`GPTMC_CTL_RTC_EN]
         & timer_control_register_r[`GPTMC_CTL_A_EN];
      half_a_pwm_o = half_a_pwm_raw_i ^ timer_control_register_r[`GPTMC_CTL_A_INV];
   end
endmodule : gptmc_top
`default_nettype wire

// ---- gptmc_top_assertions.sv ----
// Concurrent checks on the ports of the timer mode and control block.
`timescale 1ns/1ps
`default_nettype none
module gptmc_top_assertions (
   // Clock and reset.
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Bus handshakes.
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // Timer side.
   input wire logic dbg_halt_i,
   input wire logic half_a_pwm_raw_i,
   input wire gptmc_pkg::gptmc_half_type half_a_ctl_o,
   input wire gptmc_pkg::gptmc_half_type half_b_ctl_o,
   input wire logic split_16_o,
   input wire logic rtc_count_o,
   input wire logic half_a_pwm_o
);
   import gptmc_pkg::*;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   // ************************************
   // Sequences and assertions
   // ************************************
   // Both write items taken at one edge.
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // Debug halt low long enough to clear the synchroniser.
   sequence s_quiet;
      (!dbg_halt_i) [*5];
   endsequence
   a_wr_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
      else $error("write response missing");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response missing");
   a_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   a_pwm_follow: assert property (
      $changed(half_a_pwm_raw_i) && !s_axi_bvalid |-> $changed(half_a_pwm_o))
      else $error("pwm output did not follow its source");
   a_b_one_mode: assert property (
      $onehot0({half_b_ctl_o.capture, half_b_ctl_o.oneshot, half_b_ctl_o.periodic}))
      else $error("half b decodes two modes");
   a_b_needs_split: assert property (half_b_ctl_o.run |-> split_16_o)
      else $error("half b runs in a 32-bit setup");
   a_a_held_off: assert property (half_a_ctl_o.count_en |-> half_a_ctl_o.run)
      else $error("half a counts while disabled");
   a_rtc_mode: assert property (
      rtc_count_o |-> !split_16_o && !half_a_ctl_o.run)
      else $error("rtc counting outside rtc setup");
   a_a_free_run: assert property (
      s_quiet ##0 half_a_ctl_o.run |-> half_a_ctl_o.count_en)
      else $error("half a frozen without halt");
   a_b_free_run: assert property (
      s_quiet ##0 half_b_ctl_o.run |-> half_b_ctl_o.count_en)
      else $error("half b frozen without halt");
endmodule : gptmc_top_assertions
bind gptmc_top gptmc_top_assertions i_gptmc_top_assertions (.core_clk_i, .rst_i,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .dbg_halt_i, .half_a_pwm_raw_i,
   .half_a_ctl_o, .half_b_ctl_o, .split_16_o, .rtc_count_o, .half_a_pwm_o);
`default_nettype wire

// ---- gptmc_top_bench.sv ----
// Self-checking bench for the timer mode and control block.
`timescale 1ns/1ps
`default_nettype none
`include "gptmc_defs.svh"
module gptmc_top_bench;
   import gptmc_pkg::*;
   logic core_clk_i = 1'b0, rst_i = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic dbg_halt_i = 1'b0, half_a_pwm_raw_i = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic split_16_o, rtc_count_o, half_a_pwm_o;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   gptmc_half_type half_a_ctl_o, half_b_ctl_o;
   gptmc_edge_type half_a_edge_select_o;
   int fail_count = 0, comparisons = 0;
   gptmc_top i_gptmc_top (.core_clk_i, .rst_i, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .dbg_halt_i, .half_a_pwm_raw_i, .half_a_ctl_o, .half_b_ctl_o,
      .half_a_edge_select_o, .split_16_o, .rtc_count_o, .half_a_pwm_o);
   // ************************************
   // Clock, report and bus tasks
   // ************************************
   // Free-running 250 MHz clock.
   initial begin
      forever #2 core_clk_i = ~core_clk_i;
   end
   // Prints the counts and the verdict, then stops.
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : wrap_up
   // Compares one value and reports a mismatch at once.
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s expected %0h seen %0h", n, e, g);
      end
   endtask : chk
   // One bus write; items released when taken, bready held until bvalid.
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] er = `GPTMC_RESP_OKAY);
      int n;
      @(posedge core_clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge core_clk_i);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (n == 40) begin
         fail_count++;
         $display("BAD bvalid expected 1 seen 0");
         wrap_up();
      end
      chk("bresp", 32'(er), 32'(s_axi_bresp));
   endtask : wr
   // One bus read; rready held until rvalid.
   task automatic rd(input logic [11:0] a, input logic [31:0] e,
                     input logic [1:0] er = `GPTMC_RESP_OKAY);
      int n;
      @(posedge core_clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge core_clk_i);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      if (n == 40) begin
         fail_count++;
         $display("BAD rvalid expected 1 seen 0");
         wrap_up();
      end
      chk("rresp", 32'(er), 32'(s_axi_rresp));
      chk("rdata", e, s_axi_rdata);
   endtask : rd
   // Changes the debug halt input and lets the synchroniser settle.
   task automatic halt(input logic h);
      @(posedge core_clk_i);
      dbg_halt_i <= h;
      repeat (6) @(posedge core_clk_i);
   endtask : halt
   // ************************************
   // Scenarios
   // ************************************
   // Main sequence of register accesses and port checks.
   initial begin
      int i;
      logic [31:0] m [4];
      logic [5:0] mb [4];
      m = '{32'h7, 32'hF, 32'hF, 32'h35F};
      mb = '{6'h30, 6'h34, 6'h32, 6'h38};
      repeat (6) @(posedge core_clk_i);
      rst_i <= 1'b0;
      for (i = 0; i < 4; i++) begin
         rd(12'(4 * i), 32'h0);
         wr(12'(4 * i), 32'hFFFFFFFF);
         rd(12'(4 * i), m[i]);
      end
      rd(12'h100, 32'h0, `GPTMC_RESP_SLVERR);
      wr(`GPTMC_OFS_STAT, 32'h1, `GPTMC_RESP_SLVERR);
      wr(`GPTMC_OFS_CFG, 32'h4);
      wr(`GPTMC_OFS_CTL, 32'h101);
      wr(`GPTMC_OFS_AMR, 32'h1);
      for (i = 1; i < 4; i++) begin
         wr(`GPTMC_OFS_BMR, 32'(i));
         chk("half_b", 32'(mb[i]), 32'(half_b_ctl_o));
         chk("half_a", 32'h34, 32'(half_a_ctl_o));
      end
      wr(`GPTMC_OFS_BMR, 32'hA);
      chk("b_pwm", 32'h33, 32'(half_b_ctl_o));
      wr(`GPTMC_OFS_CTL, 32'h303);
      halt(1'b1);
      chk("a_frozen", 32'h24, 32'(half_a_ctl_o));
      chk("b_frozen", 32'h23, 32'(half_b_ctl_o));
      rd(`GPTMC_OFS_STAT, 32'hAA);
      wr(`GPTMC_OFS_CTL, 32'h101);
      chk("a_halted", 32'h34, 32'(half_a_ctl_o));
      chk("b_halted", 32'h33, 32'(half_b_ctl_o));
      wr(`GPTMC_OFS_CTL, 32'h303);
      halt(1'b0);
      chk("a_free", 32'h34, 32'(half_a_ctl_o));
      chk("b_free", 32'h33, 32'(half_b_ctl_o));
      wr(`GPTMC_OFS_CTL, 32'h0);
      chk("a_off", 32'h0, 32'(half_a_ctl_o[5:4]));
      chk("b_off", 32'h0, 32'(half_b_ctl_o[5:4]));
      wr(`GPTMC_OFS_CFG, 32'h0);
      wr(`GPTMC_OFS_AMR, 32'h2);
      wr(`GPTMC_OFS_CTL, 32'h101);
      chk("split", 32'h0, 32'(split_16_o));
      chk("b_ignored", 32'h0, 32'(half_b_ctl_o.run));
      chk("a_wide", 32'h32, 32'(half_a_ctl_o));
      wr(`GPTMC_OFS_CFG, 32'h1);
      wr(`GPTMC_OFS_CTL, 32'h11);
      chk("rtc_on", 32'h1, 32'(rtc_count_o));
      wr(`GPTMC_OFS_CTL, 32'h1);
      chk("rtc_off", 32'h0, 32'(rtc_count_o));
      wr(`GPTMC_OFS_CTL, 32'h40);
      for (i = 0; i < 2; i++) begin
         @(posedge core_clk_i);
         half_a_pwm_raw_i <= ~half_a_pwm_raw_i;
         @(posedge core_clk_i);
         chk("pwm_inv", 32'(i == 1), 32'(half_a_pwm_o));
      end
      wr(`GPTMC_OFS_CTL, 32'h0);
      @(posedge core_clk_i);
      half_a_pwm_raw_i <= 1'b1;
      @(posedge core_clk_i);
      chk("pwm_pass", 32'h1, 32'(half_a_pwm_o));
      for (i = 0; i < 4; i++) begin
         wr(`GPTMC_OFS_CTL, 32'(4 * i));
         if (i != 2) chk("edge", 32'(i), 32'(half_a_edge_select_o));
      end
      wrap_up();
   end
endmodule : gptmc_top_bench
`default_nettype wire
